// File: wbm_pkg.sv
package wbm_pkg;
    // Mode codes carried in the command descriptor
    localparam logic [4:0]  MODE_DATA   = 5'h02;
    localparam logic [4:0]  MODE_DL     = 5'h04;
    localparam logic [4:0]  MODE_DLS    = 5'h05;
    localparam logic [4:0]  MODE_DLSEG  = 5'h07;
    localparam logic [4:0]  MODE_ECHO   = 5'h0a;
    localparam logic [4:0]  MODE_EXP    = 5'h1a;
    // Buffer geometry in bytes, except the word count and the word address width
    localparam logic [23:0] BUF_BYTES   = 24'h001000;
    localparam logic [23:0] ECHO_BYTES  = 24'h000100;
    localparam logic [23:0] SECT_MASK   = 24'h0001ff;
    localparam logic [23:0] SEG_MASK    = 24'h000fff;
    localparam logic [23:0] WORD_BYTES  = 24'h000004;
    localparam int          BUF_WORDS   = 1024;
    localparam int          BUF_AW      = 10;
    // Sense answers
    localparam logic [3:0]  SK_GOOD     = 4'h0;
    localparam logic [3:0]  SK_ILLEGAL  = 4'h5;
    localparam logic [7:0]  ASC_NONE    = 8'h00;
    localparam logic [7:0]  ASC_INV_FLD = 8'h24;
    // Register offsets
    localparam logic [3:0]  REG_DL_SIZE  = 4'h0;
    localparam logic [3:0]  REG_FILE_LEN = 4'h1;
    localparam logic [3:0]  REG_STATUS   = 4'h2;
    localparam logic [3:0]  REG_SEG_CNT  = 4'h3;
    localparam logic [3:0]  REG_BUF_ADDR = 4'h4;
    localparam logic [3:0]  REG_BUF_DATA = 4'h5;
    // Values after reset
    localparam logic [23:0] DL_SIZE_RST  = 24'h000400;
    localparam logic [23:0] FILE_LEN_RST = 24'h002000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_XFER  = 3'b001,
        ST_APPLY = 3'b010,
        ST_SAVE  = 3'b011,
        ST_DONE  = 3'b100
    } wbm_state_t;

    typedef enum logic [2:0] {
        K_BAD  = 3'b000,
        K_DATA = 3'b001,
        K_DL   = 3'b010,
        K_DLS  = 3'b011,
        K_SEG  = 3'b100,
        K_ECHO = 3'b101
    } wbm_kind_t;
endpackage

// File: wbm_chk_if.sv
`timescale 1ns/1ps
interface wbm_chk_if;
    import wbm_pkg::*;
    logic [4:0]  mode;     // Requested mode
    logic [7:0]  buf_id;   // Buffer selector
    logic [23:0] offset;   // Buffer offset in bytes
    logic [23:0] len;      // Parameter list length
    logic [23:0] dl_size;  // Expected download data-set size
    wbm_kind_t   kind;     // Decoded mode class
    logic        bad;      // Some field is invalid

    modport chk (input mode, buf_id, offset, len, dl_size,
                 output kind, bad);
    modport user (output mode, buf_id, offset, len, dl_size,
                  input kind, bad);
endinterface

// File: wbm_field_chk.sv
`timescale 1ns/1ps
module wbm_field_chk
    import wbm_pkg::*;
(
    wbm_chk_if.chk c
);
    logic [24:0] end_pos;  // Offset plus length, one bit wider

    // Field validation per mode, purely combinational
    always_comb begin
        end_pos = {1'b0, c.offset} + {1'b0, c.len};
        c.kind  = K_BAD;
        c.bad   = 1'b0;
        unique case (c.mode)
            MODE_DATA: begin
                c.kind = K_DATA;
                c.bad  = (c.buf_id != 8'h00)
                      || (c.offset > BUF_BYTES)
                      || (end_pos >= {1'b0, BUF_BYTES})
                      || ((c.len & SECT_MASK) != 24'h000000);
            end
            MODE_DL: begin
                c.kind = K_DL;
                // Only the main processor image is supported
                c.bad  = (c.buf_id != 8'h00)
                      || (c.offset != 24'h000000)
                      || ((c.len != 24'h000000)
                          && (c.len != c.dl_size));
            end
            MODE_DLS: begin
                // Buffer ID is the initiator's concern here
                c.kind = K_DLS;
            end
            MODE_DLSEG: begin
                // Offset is not looked at in this mode
                c.kind = K_SEG;
                c.bad  = ((c.len & SEG_MASK) != 24'h000000);
            end
            MODE_ECHO, MODE_EXP: begin
                // Expander enable is handled exactly as echo
                c.kind = K_ECHO;
                c.bad  = (c.len > ECHO_BYTES);
            end
            default: begin
                c.bad  = 1'b1;
            end
        endcase
    end
endmodule

// File: wbm_handler.sv
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module wbm_handler
    import wbm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    input  wire logic [4:0]  cmd_mode,
    input  wire logic [7:0]  cmd_buf_id,
    input  wire logic [23:0] cmd_offset,
    input  wire logic [23:0] cmd_len,
    input  wire logic [3:0]  cmd_init,
    output logic             cmd_ready,
    input  wire logic        other_cmd,
    input  wire logic        din_valid,
    input  wire logic [31:0] din_data,
    output logic             din_ready,
    input  wire logic        code_ok,
    input  wire logic        save_done,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             sts_valid,
    output logic             sts_check,
    output logic [3:0]       sts_sense_key,
    output logic [7:0]       sts_asc,
    output logic             cache_flush,
    output logic             ucode_run,
    output logic             ucode_save,
    output logic             por_req,
    output logic             ua_valid,
    output logic [15:0]      ua_mask
);
    wbm_chk_if chk_if ();

    wbm_state_t       state_r, state_nxt;       // Command sequencer
    wbm_kind_t        kind_r, kind_nxt;         // Class of current command
    logic [23:0]      len_r, len_nxt;           // Bytes to receive
    logic [23:0]      cnt_r, cnt_nxt;           // Bytes received so far
    logic [BUF_AW-1:0] base_r, base_nxt;        // First word written
    logic [3:0]       init_r, init_nxt;         // Issuing initiator
    logic             chk_r, chk_nxt;           // Command ends in error
    logic [23:0]      seg_cnt_r, seg_cnt_nxt;   // Bytes of file so far
    logic             seg_abort_r, seg_abort_nxt; // Error broke the file
    logic             echo_ok_r, echo_ok_nxt;   // Echo data still intact
    logic [23:0]      dl_size_r, dl_size_nxt;   // Data-set size setting
    logic [23:0]      file_len_r, file_len_nxt; // Full file length
    logic [BUF_AW-1:0] buf_addr_r, buf_addr_nxt; // Software read pointer
    logic [31:0]      rdata_nxt;
    logic             sts_valid_nxt;
    logic             cache_flush_nxt;
    logic             ucode_run_nxt;
    logic             ucode_save_nxt;
    logic             por_req_nxt;
    logic             ua_valid_nxt;
    logic [15:0]      ua_mask_nxt;
    logic [23:0]      cnt_inc;                  // Count after this word
    logic [23:0]      seg_sum;                  // File bytes incl. this one
    logic [BUF_AW-1:0] wr_addr;                 // Word being written
    logic             mem_we;                   // Word write enable

    logic [31:0] mem [BUF_WORDS];               // Shared data/echo buffer

    // Field checker sees the command as it is offered
    assign chk_if.mode    = cmd_mode;
    assign chk_if.buf_id  = cmd_buf_id;
    assign chk_if.offset  = cmd_offset;
    assign chk_if.len     = cmd_len;
    assign chk_if.dl_size = dl_size_r;

    wbm_field_chk u_chk (
        .c (chk_if.chk)
    );

    // Handshakes are plain decodes of the state
    assign cmd_ready = (state_r == ST_IDLE);
    assign din_ready = (state_r == ST_XFER);

    // Data words land on whole-word boundaries from the base word
    assign wr_addr = base_r + cnt_r[BUF_AW+1:2];
    assign mem_we  = din_ready && din_valid;
    assign cnt_inc = cnt_r + WORD_BYTES;
    assign seg_sum = seg_cnt_r + len_r;

    // Buffer storage; no reset, contents are undefined at power up
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[wr_addr] <= din_data;
        end
    end

    // Next-state and next-output computation
    always_comb begin
        state_nxt       = state_r;
        kind_nxt        = kind_r;
        len_nxt         = len_r;
        cnt_nxt         = cnt_r;
        base_nxt        = base_r;
        init_nxt        = init_r;
        chk_nxt         = chk_r;
        seg_cnt_nxt     = seg_cnt_r;
        seg_abort_nxt   = seg_abort_r;
        echo_ok_nxt     = echo_ok_r;
        dl_size_nxt     = dl_size_r;
        file_len_nxt    = file_len_r;
        buf_addr_nxt    = buf_addr_r;
        rdata_nxt       = 32'h00000000;
        sts_valid_nxt   = 1'b0;
        cache_flush_nxt = 1'b0;
        ucode_run_nxt   = 1'b0;
        ucode_save_nxt  = 1'b0;
        por_req_nxt     = 1'b0;
        ua_valid_nxt    = 1'b0;
        ua_mask_nxt     = ua_mask;

        // Any command for another unit may disturb echo data
        if (other_cmd) begin
            echo_ok_nxt = 1'b0;
        end

        unique case (state_r)
            ST_IDLE: begin
                if (cmd_valid) begin
                    // Cache is emptied whatever the outcome
                    cache_flush_nxt = 1'b1;
                    kind_nxt = chk_if.kind;
                    len_nxt  = cmd_len;
                    init_nxt = cmd_init;
                    cnt_nxt  = 24'h000000;
                    base_nxt = (chk_if.kind == K_DATA)
                             ? cmd_offset[BUF_AW+1:2] : '0;
                    chk_nxt  = chk_if.bad;
                    if (chk_if.kind == K_ECHO) begin
                        echo_ok_nxt = 1'b0;
                    end
                    if (chk_if.bad) begin
                        // No data phase at all on a bad field
                        state_nxt = ST_DONE;
                        if (chk_if.kind == K_SEG) begin
                            seg_cnt_nxt   = 24'h000000;
                            seg_abort_nxt = 1'b1;
                        end
                    end else if (cmd_len == 24'h000000) begin
                        // Nothing to move; apart from the flush, only echo clears echo_ok_r
                        state_nxt = ST_DONE;
                    end else begin
                        state_nxt = ST_XFER;
                        if (chk_if.kind == K_SEG) begin
                            // After an error, ID zero opens a new file
                            if (seg_abort_r
                                && (cmd_buf_id == 8'h00)) begin
                                seg_cnt_nxt = 24'h000000;
                            end
                            seg_abort_nxt = 1'b0;
                        end
                    end
                end
            end
            ST_XFER: begin
                if (din_valid) begin
                    cnt_nxt = cnt_inc;
                    // Last word may be a partial one for echo data
                    if (cnt_inc >= len_r) begin
                        state_nxt = ST_APPLY;
                    end
                end
            end
            ST_APPLY: begin
                state_nxt = ST_DONE;
                unique case (kind_r)
                    K_DL: begin
                        if (code_ok) begin
                            // Runs now, lost at next power cycle
                            ucode_run_nxt = 1'b1;
                            ua_valid_nxt  = 1'b1;
                            ua_mask_nxt   = ~(16'h0001 << init_r);
                        end else begin
                            chk_nxt = 1'b1;
                        end
                    end
                    K_DLS: begin
                        if (code_ok) begin
                            ucode_save_nxt = 1'b1;
                            state_nxt      = ST_SAVE;
                        end else begin
                            chk_nxt = 1'b1;
                        end
                    end
                    K_SEG: begin
                        seg_cnt_nxt = seg_sum;
                        // Whole file in: same path as a single file
                        if (seg_sum == file_len_r) begin
                            seg_cnt_nxt = 24'h000000;
                            if (code_ok) begin
                                ucode_save_nxt = 1'b1;
                                state_nxt      = ST_SAVE;
                            end else begin
                                chk_nxt = 1'b1;
                            end
                        end
                    end
                    K_ECHO: begin
                        echo_ok_nxt = 1'b1;
                    end
                    default: state_nxt = ST_DONE;
                endcase
            end
            ST_SAVE: begin
                // Permanent copy written; new code needs a reset
                if (save_done) begin
                    por_req_nxt  = 1'b1;
                    ua_valid_nxt = 1'b1;
                    ua_mask_nxt  = ~(16'h0001 << init_r);
                    state_nxt    = ST_DONE;
                end
            end
            ST_DONE: begin
                sts_valid_nxt = 1'b1;
                state_nxt     = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        // Register writes; the size setting steers the download check, the file length the segment total
        if (reg_wr) begin
            unique case (reg_addr)
                REG_DL_SIZE:  dl_size_nxt  = reg_wdata[23:0];
                REG_FILE_LEN: file_len_nxt = reg_wdata[23:0];
                REG_BUF_ADDR: buf_addr_nxt = reg_wdata[BUF_AW-1:0];
                default:      dl_size_nxt  = dl_size_nxt;
            endcase
        end
        // Register reads; unmapped offsets answer zero
        if (reg_rd) begin
            unique case (reg_addr)
                REG_DL_SIZE:  rdata_nxt = {8'h00, dl_size_r};
                REG_FILE_LEN: rdata_nxt = {8'h00, file_len_r};
                REG_STATUS:   rdata_nxt = {25'h0000000, state_r,
                                           seg_abort_r, echo_ok_r,
                                           chk_r, ~cmd_ready};
                REG_SEG_CNT:  rdata_nxt = {8'h00, seg_cnt_r};
                REG_BUF_ADDR: rdata_nxt = {22'h000000, buf_addr_r};
                REG_BUF_DATA: rdata_nxt = mem[buf_addr_r];
                default:      rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Registers only; sense fields follow the error flag
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r       <= ST_IDLE;
            kind_r        <= K_BAD;
            len_r         <= 24'h000000;
            cnt_r         <= 24'h000000;
            base_r        <= '0;
            init_r        <= 4'h0;
            chk_r         <= 1'b0;
            seg_cnt_r     <= 24'h000000;
            seg_abort_r   <= 1'b0;
            echo_ok_r     <= 1'b0;
            dl_size_r     <= DL_SIZE_RST;
            file_len_r    <= FILE_LEN_RST;
            buf_addr_r    <= '0;
            reg_rdata     <= 32'h00000000;
            sts_valid     <= 1'b0;
            sts_check     <= 1'b0;
            sts_sense_key <= SK_GOOD;
            sts_asc       <= ASC_NONE;
            cache_flush   <= 1'b0;
            ucode_run     <= 1'b0;
            ucode_save    <= 1'b0;
            por_req       <= 1'b0;
            ua_valid      <= 1'b0;
            ua_mask       <= 16'h0000;
        end else begin
            state_r       <= state_nxt;
            kind_r        <= kind_nxt;
            len_r         <= len_nxt;
            cnt_r         <= cnt_nxt;
            base_r        <= base_nxt;
            init_r        <= init_nxt;
            chk_r         <= chk_nxt;
            seg_cnt_r     <= seg_cnt_nxt;
            seg_abort_r   <= seg_abort_nxt;
            echo_ok_r     <= echo_ok_nxt;
            dl_size_r     <= dl_size_nxt;
            file_len_r    <= file_len_nxt;
            buf_addr_r    <= buf_addr_nxt;
            reg_rdata     <= rdata_nxt;
            sts_valid     <= sts_valid_nxt;
            sts_check     <= sts_valid_nxt & chk_r;
            sts_sense_key <= (sts_valid_nxt & chk_r) ? SK_ILLEGAL
                                                     : SK_GOOD;
            sts_asc       <= (sts_valid_nxt & chk_r) ? ASC_INV_FLD
                                                     : ASC_NONE;
            cache_flush   <= cache_flush_nxt;
            ucode_run     <= ucode_run_nxt;
            ucode_save    <= ucode_save_nxt;
            por_req       <= por_req_nxt;
            ua_valid      <= ua_valid_nxt;
            ua_mask       <= ua_mask_nxt;
        end
    end

    // A rejected command ends with check status two cycles on
    a_bad_check: assert property (@(posedge clk) disable iff (rst)
        (cmd_ready && cmd_valid && chk_if.bad)
        |-> ##2 (sts_valid && sts_check && sts_asc == ASC_INV_FLD))
        else $error("bad field not reported");
    // A rejected command never opens the data phase
    a_no_xfer: assert property (@(posedge clk) disable iff (rst)
        (cmd_ready && cmd_valid && chk_if.bad) |=> !din_ready [*2])
        else $error("data phase after bad field");
    // Zero length returns good status without data
    a_zero_len: assert property (@(posedge clk) disable iff (rst)
        (cmd_ready && cmd_valid && !chk_if.bad && cmd_len == 24'h0)
        |=> !din_ready ##1 (sts_valid && !sts_check))
        else $error("zero length not short-cut");
    // Every accepted command flushes the cache
    a_flush_cmd: assert property (@(posedge clk) disable iff (rst)
        (cmd_ready && cmd_valid) |=> cache_flush)
        else $error("cache not flushed");
    // Attention skips only the issuing initiator
    a_ua_others: assert property (@(posedge clk) disable iff (rst)
        ua_valid |-> (!ua_mask[init_r] && $countones(ua_mask) == 15))
        else $error("attention mask wrong");
    // Self reset only once the save has completed
    a_por_save: assert property (@(posedge clk) disable iff (rst)
        por_req |-> ($past(state_r) == ST_SAVE && $past(save_done)))
        else $error("reset before save done");
    // New code runs only when it was accepted
    a_run_ok: assert property (@(posedge clk) disable iff (rst)
        ucode_run |-> ($past(code_ok) && $past(kind_r) == K_DL))
        else $error("invalid code started");
    // Segment count cleared when a segment is refused
    a_seg_clear: assert property (@(posedge clk) disable iff (rst)
        (cmd_ready && cmd_valid && chk_if.bad && chk_if.kind == K_SEG)
        |=> (seg_cnt_r == 24'h0 && seg_abort_r))
        else $error("segment count kept after error");
endmodule

// File: wbm_init_model.sv
`timescale 1ns/1ps
// Initiator side: streams data-out words and plays the flash engine
module wbm_init_model #(
    parameter int SAVE_WAIT = 20  // Shortened save wait, in cycles
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        din_ready,
    input  wire logic        ucode_save,
    output logic             din_valid,
    output logic [31:0]      din_data,
    output logic             save_done
);
    logic [15:0] idx_r;   // Word index within the current transfer
    logic [7:0]  wait_r;  // Save countdown
    // Words always on offer in the data phase, in file order
    assign din_valid = din_ready;
    // Outside the phase the line shows the inverse, not a stale word
    assign din_data  = din_ready ? {16'h5a5a, idx_r} : ~{16'h5a5a, idx_r};
    // Save ends after a fixed wait, standing in for the long flash update
    assign save_done = (wait_r == 8'h01);
    // Index restarts at every phase; countdown starts at each save
    always_ff @(posedge clk) begin
        idx_r  <= (rst || !din_ready) ? 16'h0000 : idx_r + 16'h0001;
        if (rst)
            wait_r <= 8'h00;
        else if (ucode_save)
            wait_r <= 8'(SAVE_WAIT);
        else if (wait_r != 8'h00)
            wait_r <= wait_r - 8'h01;
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import wbm_pkg::*;
    logic        clk = 0, rst = 1, cmd_valid = 0, reg_wr = 0, reg_rd = 0;
    logic        other_cmd = 0, code_ok = 1;
    logic [4:0]  cmd_mode = 5'h00, fl;      // Pulses seen in a command
    logic [7:0]  cmd_buf_id = 8'h00;
    logic [23:0] cmd_offset = 24'h0, cmd_len = 24'h0;
    logic [3:0]  cmd_init = 4'h3, reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, din_data;
    logic        cmd_ready, din_valid, din_ready, save_done, sts_valid;
    logic        sts_check, cache_flush, ucode_run, ucode_save, por_req;
    logic        ua_valid;
    logic [3:0]  sts_sense_key;
    logic [7:0]  sts_asc;
    logic [15:0] ua_mask, um;               // Last attention mask seen
    int          error_cnt = 0, checks_done = 0, cyc = 0;
    wire  [4:0]  pulses = {cache_flush, ucode_run, ucode_save, por_req,
                           ua_valid};
    wire  [12:0] sv = {sts_check, sts_sense_key, sts_asc};

    wbm_handler u_dut (.clk, .rst, .cmd_valid, .cmd_mode, .cmd_buf_id,
        .cmd_offset, .cmd_len, .cmd_init, .cmd_ready, .other_cmd,
        .din_valid, .din_data, .din_ready, .code_ok, .save_done,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sts_valid,
        .sts_check, .sts_sense_key, .sts_asc, .cache_flush, .ucode_run,
        .ucode_save, .por_req, .ua_valid, .ua_mask);
    wbm_init_model u_init (.clk, .rst, .din_ready, .ucode_save,
        .din_valid, .din_data, .save_done);

    initial forever #12.5 clk = ~clk;
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Register read; data stand only in the cycle after the strobe
    task automatic rr(input logic [3:0] a, input logic [31:0] m, e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata & m);
    endtask
    // One command: offer, gather pulses until status, compare
    task automatic cr(input logic [4:0] m, input logic [7:0] id,
                      input logic [23:0] o, l, input logic [4:0] ef,
                      input logic c);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_mode   <= m;
        cmd_buf_id <= id;
        cmd_offset <= o;
        cmd_len    <= l;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 fl = pulses;
        // Forget any earlier mask so a missing attention is seen
        um = 16'h0000;
        chk("cmd_ready", 32'h0, {31'h0, cmd_ready});
        for (int i = 0; i < 6000 && sts_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1 fl = fl | pulses;
            if (ua_valid === 1'b1)
                um = ua_mask;
        end
        chk("sts_valid", 32'h1, {31'h0, sts_valid});
        chk("pulses", {27'h0, ef}, {27'h0, fl});
        chk("status", c ? 32'h1524 : 32'h0, {19'h0, sv});
        chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rr(REG_DL_SIZE, 32'hffffff, 32'h400);
        rr(REG_FILE_LEN, 32'hffffff, 32'h2000);
        rr(4'h9, 32'hffffffff, 32'h0);
        cr(MODE_DATA, 8'h01, 24'h0, 24'h200, 5'h10, 1'b1);
        cr(MODE_DATA, 8'h00, 24'h1001, 24'h200, 5'h10, 1'b1);
        cr(MODE_DATA, 8'h00, 24'h0, 24'h100, 5'h10, 1'b1);
        cr(MODE_DATA, 8'h00, 24'he00, 24'h200, 5'h10, 1'b1);
        cr(MODE_DATA, 8'h00, 24'h0, 24'h0, 5'h10, 1'b0);
        cr(MODE_DATA, 8'h00, 24'h8, 24'h200, 5'h10, 1'b0);
        wr(REG_BUF_ADDR, 32'h3);
        rr(REG_BUF_DATA, 32'hffffffff, 32'h5a5a0001);
        cr(5'h00, 8'h00, 24'h0, 24'h200, 5'h10, 1'b1);
        cr(5'h03, 8'h00, 24'h0, 24'h200, 5'h10, 1'b1);
        $display("test data mode done");
        cr(MODE_DL, 8'h01, 24'h0, 24'h400, 5'h10, 1'b1);
        cr(MODE_DL, 8'h00, 24'h4, 24'h400, 5'h10, 1'b1);
        cr(MODE_DL, 8'h00, 24'h0, 24'h3fc, 5'h10, 1'b1);
        cr(MODE_DL, 8'h00, 24'h0, 24'h0, 5'h10, 1'b0);
        wr(REG_DL_SIZE, 32'h8);
        cr(MODE_DL, 8'h00, 24'h0, 24'h8, 5'h19, 1'b0);
        chk("ua_mask", 32'hfff7, {16'h0, um});
        @(posedge clk) code_ok <= 1'b0;
        cr(MODE_DL, 8'h00, 24'h0, 24'h8, 5'h10, 1'b1);
        @(posedge clk) code_ok <= 1'b1;
        $display("test download done");
        cr(MODE_ECHO, 8'h00, 24'h0, 24'h8, 5'h10, 1'b0);
        rr(REG_STATUS, 32'h4, 32'h4);
        @(posedge clk) other_cmd <= 1'b1;
        @(posedge clk) other_cmd <= 1'b0;
        rr(REG_STATUS, 32'h4, 32'h0);
        cr(MODE_EXP, 8'h00, 24'h0, 24'h8, 5'h10, 1'b0);
        rr(REG_STATUS, 32'h4, 32'h4);
        $display("test echo done");
        @(posedge clk) cmd_init <= 4'h9;
        cr(MODE_DLS, 8'h00, 24'h0, 24'h8, 5'h17, 1'b0);
        chk("ua_mask", 32'hfdff, {16'h0, um});
        @(posedge clk) code_ok <= 1'b0;
        cr(MODE_DLS, 8'h00, 24'h0, 24'h8, 5'h10, 1'b1);
        @(posedge clk) code_ok <= 1'b1;
        @(posedge clk) cmd_init <= 4'h3;
        $display("test single save done");
        cr(MODE_DLSEG, 8'h05, 24'h123, 24'h1000, 5'h10, 1'b0);
        rr(REG_SEG_CNT, 32'hffffff, 32'h1000);
        cr(MODE_DLSEG, 8'h00, 24'h0, 24'h800, 5'h10, 1'b1);
        rr(REG_SEG_CNT, 32'hffffff, 32'h0);
        cr(MODE_DLSEG, 8'h00, 24'h0, 24'h1000, 5'h10, 1'b0);
        cr(MODE_DLSEG, 8'h07, 24'h0, 24'h1000, 5'h17, 1'b0);
        chk("ua_mask", 32'hfff7, {16'h0, um});
        rr(REG_SEG_CNT, 32'hffffff, 32'h0);
        $display("test segmented save done");
        complete_run();
    end
endmodule
